// file: gp_params.svh
// Register indices, port numbers, reset values and bus answers of the GPIO port block
`ifndef GP_PARAMS_SVH
`define GP_PARAMS_SVH

// Register index inside one port (word address bits 2:0)
`define GP_REG_LEVEL   3'h0
`define GP_REG_LATCH   3'h1
`define GP_REG_DIR     3'h2
`define GP_REG_ANSEL   3'h3
`define GP_REG_PULLUP  3'h4
`define GP_REG_THRESH  3'h5
`define GP_REG_SLEW    3'h6
`define GP_REG_ODRAIN  3'h7

// Port number (word address bits 5:3)
`define GP_PORT_A      3'h0
`define GP_PORT_D      3'h3
`define GP_NPORT       3'h5

// Reset values
`define GP_RST_LAT     8'h00
`define GP_RST_DIR     8'hFF
`define GP_RST_ANSEL   8'hFF
`define GP_RST_PAD     8'h00

// Bus answers
`define GP_RSP_OK      2'h0
`define GP_RSP_DECERR  2'h3

`endif

// file: gp_pkg.sv
// Types shared by the GPIO port block
package gp_pkg;
   typedef logic [7:0] gp_byte_t;
   // Pin owner, highest priority first
   typedef enum logic [1:0] {
      GP_OWN_CFG,
      GP_OWN_AOUT,
      GP_OWN_AIN,
      GP_OWN_DIG
   } gp_own_e;
endpackage : gp_pkg

// file: gp_port.sv
// One eight-pin port: control registers, pin synchroniser and register read mux
`timescale 1ns/1ps
`default_nettype none
`include "gp_params.svh"
module gp_port (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             sys_rst_i,
   // Register access
   input  wire logic             wr_en_i,
   input  wire logic [2:0]       idx_i,
   input  wire gp_pkg::gp_byte_t wdata_i,
   output var  gp_pkg::gp_byte_t rdata_o,
   // Pin levels
   input  wire logic [7:0]       pin_i,
   // Register contents
   output logic [7:0]            lat_o,
   output logic [7:0]            dir_o,
   output logic [7:0]            ansel_o,
   output logic [7:0]            pullup_o,
   output logic [7:0]            thresh_o,
   output logic [7:0]            slew_o,
   output logic [7:0]            odrain_o,
   output logic [7:0]            level_o
);
   import gp_pkg::*;

   gp_byte_t lat_r;
   gp_byte_t dir_r;
   gp_byte_t ansel_r;
   gp_byte_t pu_r;
   gp_byte_t th_r;
   gp_byte_t sl_r;
   gp_byte_t od_r;
   gp_byte_t s1_r;
   gp_byte_t s2_r;
   gp_byte_t s3_r;
   gp_byte_t lvl_r;
   gp_byte_t lvl_nxt;
   gp_byte_t agree_w;
   logic     wr_lat_w;

   // Writes to the level or latch register both land in the latch
   assign wr_lat_w = wr_en_i && (idx_i == `GP_REG_LEVEL || idx_i == `GP_REG_LATCH); // R2

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         lat_r   <= `GP_RST_LAT;
         dir_r   <= `GP_RST_DIR;
         ansel_r <= `GP_RST_ANSEL; // R15
         pu_r    <= `GP_RST_PAD;
         th_r    <= `GP_RST_PAD;
         sl_r    <= `GP_RST_PAD;
         od_r    <= `GP_RST_PAD;
      end else begin
         if (wr_lat_w) lat_r <= wdata_i; // R2
         if (wr_en_i && idx_i == `GP_REG_DIR) dir_r <= wdata_i; // R1
         if (wr_en_i && idx_i == `GP_REG_ANSEL) ansel_r <= wdata_i; // R1
         if (wr_en_i && idx_i == `GP_REG_PULLUP) pu_r <= wdata_i; // R1
         if (wr_en_i && idx_i == `GP_REG_THRESH) th_r <= wdata_i; // R1
         if (wr_en_i && idx_i == `GP_REG_SLEW) sl_r <= wdata_i; // R1
         if (wr_en_i && idx_i == `GP_REG_ODRAIN) od_r <= wdata_i; // R1
      end
   end

   // Three-stage pin synchroniser; a bit changes once stages two and three agree
   assign agree_w = ~(s2_r ^ s3_r);
   assign lvl_nxt = (agree_w & s3_r) | (~agree_w & lvl_r); // R16

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         s1_r  <= 8'h00;
         s2_r  <= 8'h00;
         s3_r  <= 8'h00;
         lvl_r <= 8'h00;
      end else begin
         s1_r  <= pin_i;
         s2_r  <= s1_r;
         s3_r  <= s2_r;
         lvl_r <= lvl_nxt;
      end
   end

   // Analog pins have their digital input buffer off and read as zero
   assign level_o = lvl_r & ~ansel_r; // R5 R14

   assign lat_o    = lat_r;
   assign dir_o    = dir_r;
   assign ansel_o  = ansel_r;
   assign pullup_o = pu_r;
   assign thresh_o = th_r;
   assign slew_o   = sl_r;
   assign odrain_o = od_r;

   assign rdata_o = (idx_i == `GP_REG_LEVEL)  ? level_o : // R4
                    (idx_i == `GP_REG_LATCH)  ? lat_r :   // R3
                    (idx_i == `GP_REG_DIR)    ? dir_r :
                    (idx_i == `GP_REG_ANSEL)  ? ansel_r :
                    (idx_i == `GP_REG_PULLUP) ? pu_r :
                    (idx_i == `GP_REG_THRESH) ? th_r :
                    (idx_i == `GP_REG_SLEW)   ? sl_r : od_r;
endmodule : gp_port
`default_nettype wire

// file: gp_top.sv
// GPIO port block: Avalon-MM register slave, port banks and pin ownership
// What this block does
// R1: Each port has eight registers: level, latch, direction, analog, pull-up, threshold, slew, drain.
// R2: Writing the latch register acts exactly like writing the level register.
// R3: Reading the latch register returns the latch contents, not pins.
// R4: Reading the level register returns the sampled pin levels.
// R5: A set analog select bit turns off that pin's digital input buffer.
// R6: An enabled peripheral takes the pin from the latch; the pin stays readable.
// R7: After reset every pin's output source is the port latch.
// R8: Analog inputs connect to a pin only while its analog bit is set.
// R9: Analog mode does not stop a digital output from driving the pin.
// R10: An enabled analog output wins over digital outputs and floats the driver.
// R11: Ownership priority: configuration, analog output, analog input, then digital.
// R12: Ports A, B, C and E always exist; port D only in the large variant.
// R13: Direction one makes a pin input; zero drives the latch onto the pin.
// R14: A pin in analog mode reads back as zero.
// R15: Analog select bits reset to analog mode.
// R16: Registers are eight bits, one bit per pin, pins independent.
`timescale 1ns/1ps
`default_nettype none
`include "gp_params.svh"
module gp_top #(
   parameter bit HAS_BANK_D = 1'b1,
   parameter int NPORT      = 5,
   parameter int NPIN       = NPORT * 8
) (
   // Clock and reset
   input  wire logic            clk_i,
   input  wire logic            sys_rst_i,
   // Avalon-MM slave
   input  wire logic [5:0]      avs_address_i,
   input  wire logic            avs_read_i,
   input  wire logic            avs_write_i,
   input  wire logic [31:0]     avs_writedata_i,
   input  wire logic [3:0]      avs_byteenable_i,
   output logic [31:0]          avs_readdata_o,
   output logic                 avs_waitrequest_o,
   output logic [1:0]           avs_response_o,
   // Pads
   input  wire logic [NPIN-1:0] pin_i,
   output logic [NPIN-1:0]      pin_o,
   output logic [NPIN-1:0]      pin_oe_o,
   output logic [NPIN-1:0]      pullup_en_o,
   output logic [NPIN-1:0]      slew_lim_o,
   output logic [NPIN-1:0]      ttl_sel_o,
   // Configuration bits and analog side
   input  wire logic [NPIN-1:0] cfg_own_i,
   input  wire logic [NPIN-1:0] aout_en_i,
   output logic [NPIN-1:0]      ana_in_en_o,
   // Peripheral pin router side
   input  wire logic [NPIN-1:0] pps_en_i,
   input  wire logic [NPIN-1:0] pps_out_i,
   output logic [NPIN-1:0]      dig_in_o
);
   import gp_pkg::*;

   localparam logic [4:0] PRESENT_M = HAS_BANK_D ? 5'h1F : 5'h17;

   // Bus decode
   logic [2:0]      port_sel_w;
   logic [2:0]      reg_sel_w;
   logic            port_ok_w;
   logic            mapped_w;
   logic            wr_acc_w;
   logic            rd_take_w;
   gp_byte_t        rsel_w;
   logic            rd_pend_r;
   logic [31:0]     rdata_r;
   logic [1:0]      rsp_r;

   // Port bank contents, flattened one bit per pin
   gp_byte_t        rdat_w [NPORT];
   logic [NPORT-1:0] wr_w;
   logic [NPIN-1:0] lat_w;
   logic [NPIN-1:0] dir_w;
   logic [NPIN-1:0] ansel_w;
   logic [NPIN-1:0] od_w;
   logic [NPIN-1:0] dlvl_w;
   logic [NPIN-1:0] here_w;

   // Pin ownership and drive
   gp_own_e         own_w [NPIN];
   logic [NPIN-1:0] dat_w;
   logic [NPIN-1:0] drv_w;
   logic [NPIN-1:0] oe_nxt;
   logic [NPIN-1:0] out_nxt;
   logic [NPIN-1:0] ain_nxt;
   logic [NPIN-1:0] pin_r;
   logic [NPIN-1:0] oe_r;
   logic [NPIN-1:0] ain_r;

   assign port_sel_w = avs_address_i[5:3];
   assign reg_sel_w  = avs_address_i[2:0];
   assign port_ok_w  = port_sel_w < `GP_NPORT;
   // Port D decodes only in the large variant
   assign mapped_w   = port_ok_w && PRESENT_M[port_sel_w]; // R12
   assign wr_acc_w   = avs_write_i && mapped_w && avs_byteenable_i[0];
   assign rd_take_w  = avs_read_i && !rd_pend_r;
   assign rsel_w     = mapped_w ? rdat_w[port_sel_w] : 8'h00;

   // Reads wait one cycle; writes are taken at once
   assign avs_waitrequest_o = avs_read_i && !rd_pend_r;
   assign avs_readdata_o    = rdata_r;
   assign avs_response_o    = rsp_r;

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         rd_pend_r <= 1'b0;
         rdata_r   <= 32'h0000_0000;
         rsp_r     <= `GP_RSP_OK;
      end else if (rd_take_w) begin
         rd_pend_r <= 1'b1;
         rdata_r   <= {24'h00_0000, rsel_w};
         rsp_r     <= mapped_w ? `GP_RSP_OK : `GP_RSP_DECERR; // R12
      end else begin
         rd_pend_r <= 1'b0;
      end
   end

   // One register bank per port
   for (genvar p = 0; p < NPORT; p++) begin : g_port
      assign wr_w[p]  = wr_acc_w && port_sel_w == 3'(p); // R16
      assign here_w[p*8 +: 8] = {8{PRESENT_M[p]}};
      gp_port u_port (
         .clk_i    (clk_i),
         .sys_rst_i(sys_rst_i),
         .wr_en_i  (wr_w[p]),
         .idx_i    (reg_sel_w),
         .wdata_i  (avs_writedata_i[7:0]),
         .rdata_o  (rdat_w[p]),
         .pin_i    (pin_i[p*8 +: 8]),
         .lat_o    (lat_w[p*8 +: 8]),
         .dir_o    (dir_w[p*8 +: 8]),
         .ansel_o  (ansel_w[p*8 +: 8]),
         .pullup_o (pullup_en_o[p*8 +: 8]),
         .thresh_o (ttl_sel_o[p*8 +: 8]),
         .slew_o   (slew_lim_o[p*8 +: 8]),
         .odrain_o (od_w[p*8 +: 8]),
         .level_o  (dlvl_w[p*8 +: 8])
      );
   end

   // Per-pin owner and driver
   for (genvar i = 0; i < NPIN; i++) begin : g_pin
      assign own_w[i] = cfg_own_i[i] ? GP_OWN_CFG :   // R11
                        aout_en_i[i] ? GP_OWN_AOUT :  // R10
                        ansel_w[i]   ? GP_OWN_AIN :   // R8
                                       GP_OWN_DIG;
      // Router source when enabled, otherwise the latch
      assign dat_w[i] = pps_en_i[i] ? pps_out_i[i] : lat_w[i]; // R6 R7
      // Digital drive in digital and analog-input modes
      assign drv_w[i] = (own_w[i] == GP_OWN_DIG || own_w[i] == GP_OWN_AIN) // R9
                        && !dir_w[i] && here_w[i]; // R13
      // Open drain only pulls low
      assign oe_nxt[i]  = drv_w[i] && !(od_w[i] && dat_w[i]);
      assign out_nxt[i] = dat_w[i] && !od_w[i];
      assign ain_nxt[i] = own_w[i] == GP_OWN_AIN && here_w[i]; // R8
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         pin_r <= '0;
         oe_r  <= '0;
         ain_r <= '0;
      end else begin
         pin_r <= out_nxt;
         oe_r  <= oe_nxt;
         ain_r <= ain_nxt;
      end
   end

   assign pin_o       = pin_r;
   assign pin_oe_o    = oe_r;
   assign ana_in_en_o = ain_r;
   // Pin stays readable whoever owns it, unless its analog select bit is set or its port is absent
   assign dig_in_o    = dlvl_w & here_w; // R6

   // Checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (sys_rst_i);

   property p_rd_wait;
      avs_read_i && avs_waitrequest_o |=> !avs_waitrequest_o;
   endproperty
   a_rd_wait: assert property (p_rd_wait)
      else $error("read not answered in one cycle");

   property p_lat_wr;
      avs_write_i && avs_address_i == {`GP_PORT_A, `GP_REG_LATCH} && avs_byteenable_i[0]
      |=> lat_w[7:0] == $past(avs_writedata_i[7:0]);
   endproperty
   a_lat_wr: assert property (p_lat_wr) // R2
      else $error("latch write lost");

   property p_lvl_wr;
      avs_write_i && avs_address_i == {`GP_PORT_A, `GP_REG_LEVEL} && avs_byteenable_i[0]
      |=> lat_w[7:0] == $past(avs_writedata_i[7:0]);
   endproperty
   a_lvl_wr: assert property (p_lvl_wr) // R2
      else $error("level write did not reach latch");

   property p_lat_rd;
      avs_read_i && !avs_waitrequest_o && avs_address_i == {`GP_PORT_A, `GP_REG_LATCH}
      |-> avs_readdata_o[7:0] == $past(lat_w[7:0]);
   endproperty
   a_lat_rd: assert property (p_lat_rd) // R3
      else $error("latch read wrong");

   property p_lvl_rd;
      avs_read_i && !avs_waitrequest_o && avs_address_i == {`GP_PORT_A, `GP_REG_LEVEL}
      |-> avs_readdata_o[7:0] == $past(dlvl_w[7:0]);
   endproperty
   a_lvl_rd: assert property (p_lvl_rd) // R4
      else $error("level read wrong");

   property p_ain_zero;
      avs_read_i && !avs_waitrequest_o && avs_address_i == {`GP_PORT_A, `GP_REG_LEVEL}
      && $past(ansel_w[7:0]) == 8'hFF |-> avs_readdata_o[7:0] == 8'h00;
   endproperty
   a_ain_zero: assert property (p_ain_zero) // R14
      else $error("analog pin read not zero");

   property p_buf_off;
      (dig_in_o & ansel_w) == '0;
   endproperty
   a_buf_off: assert property (p_buf_off) // R5
      else $error("digital input seen on analog pin");

   property p_aout;
      aout_en_i != '0 |=> (pin_oe_o & $past(aout_en_i)) == '0;
   endproperty
   a_aout: assert property (p_aout) // R10
      else $error("driver on under analog output");

   property p_cfg;
      cfg_own_i != '0 |=> (pin_oe_o & $past(cfg_own_i)) == '0
                          && (ana_in_en_o & $past(cfg_own_i)) == '0;
   endproperty
   a_cfg: assert property (p_cfg) // R11
      else $error("configuration owner overridden");

   property p_ain_en;
      ##1 (ana_in_en_o & ~$past(ansel_w)) == '0;
   endproperty
   a_ain_en: assert property (p_ain_en) // R8
      else $error("analog input on digital pin");

   property p_pps;
      pps_en_i[0] && !cfg_own_i[0] && !aout_en_i[0] && !dir_w[0] && !od_w[0]
      |=> pin_oe_o[0] && pin_o[0] == $past(pps_out_i[0]);
   endproperty
   a_pps: assert property (p_pps) // R6
      else $error("router output not on pin");

   property p_latch_drv;
      !pps_en_i[0] && !cfg_own_i[0] && !aout_en_i[0] && !dir_w[0] && !od_w[0]
      |=> pin_oe_o[0] && pin_o[0] == $past(lat_w[0]);
   endproperty
   a_latch_drv: assert property (p_latch_drv) // R13
      else $error("latch not driven on output pin");

   property p_dir_in;
      dir_w[0] |=> !pin_oe_o[0];
   endproperty
   a_dir_in: assert property (p_dir_in) // R13
      else $error("input pin driven");

   property p_ana_dig;
      ansel_w[0] && !dir_w[0] && !cfg_own_i[0] && !aout_en_i[0]
      && !(od_w[0] && pps_en_i[0] ? pps_out_i[0] : od_w[0] && lat_w[0])
      |=> pin_oe_o[0];
   endproperty
   a_ana_dig: assert property (p_ana_dig) // R9
      else $error("analog mode blocked digital output");

   property p_rst;
      disable iff (1'b0)
      sys_rst_i |=> ansel_w == '1 && dir_w == '1 && lat_w == '0 && pin_oe_o == '0;
   endproperty
   a_rst: assert property (p_rst) // R15
      else $error("reset state wrong");

   property p_indep;
      wr_w[0] |=> $stable(lat_w[15:8]) && $stable(dir_w[15:8]);
   endproperty
   a_indep: assert property (p_indep) // R16
      else $error("port write leaked into other port");

   property p_no_d;
      avs_read_i && !avs_waitrequest_o && port_sel_w == `GP_PORT_D && !HAS_BANK_D
      |-> avs_response_o == `GP_RSP_DECERR;
   endproperty
   a_no_d: assert property (p_no_d) // R12
      else $error("absent port answered");

   property p_wr_nowait;
      avs_write_i |-> !avs_waitrequest_o;
   endproperty
   a_wr_nowait: assert property (p_wr_nowait) // R1
      else $error("write made to wait");

   property p_be_off;
      avs_write_i && !avs_byteenable_i[0] && port_sel_w == `GP_PORT_A
      |=> $stable(lat_w[7:0]) && $stable(dir_w[7:0]) && $stable(ansel_w[7:0]) && $stable(od_w[7:0]);
   endproperty
   a_be_off: assert property (p_be_off) // R16
      else $error("write without byte enable changed a register");

   property p_unmapped;
      avs_read_i && !avs_waitrequest_o && port_sel_w >= `GP_NPORT
      |-> avs_response_o == `GP_RSP_DECERR && avs_readdata_o == 32'h0000_0000;
   endproperty
   a_unmapped: assert property (p_unmapped) // R12
      else $error("unmapped read not refused");

   property p_rd_ok;
      avs_read_i && !avs_waitrequest_o && port_sel_w < `GP_NPORT && (HAS_BANK_D || port_sel_w != `GP_PORT_D)
      |-> avs_response_o == `GP_RSP_OK && avs_readdata_o[31:8] == 24'h00_0000;
   endproperty
   a_rd_ok: assert property (p_rd_ok) // R16
      else $error("mapped read answer wrong");

   property p_absent;
      !HAS_BANK_D |-> pin_oe_o[`GP_PORT_D*8 +: 8] == 8'h00
                      && ana_in_en_o[`GP_PORT_D*8 +: 8] == 8'h00 && dig_in_o[`GP_PORT_D*8 +: 8] == 8'h00;
   endproperty
   a_absent: assert property (p_absent) // R12
      else $error("absent port pins in use");

   property p_lvl_sync;
      $stable(pin_i[0]) [*4]
      |=> ansel_w[0] || dig_in_o[0] == $past(pin_i[0]);
   endproperty
   a_lvl_sync: assert property (p_lvl_sync) // R4
      else $error("steady pin level not seen");

   c_rd: cover property (avs_read_i && !avs_waitrequest_o && mapped_w);
   c_pps: cover property (pps_en_i[0] && !dir_w[0] ##1 pin_oe_o[0]);
   c_aout: cover property (aout_en_i[0] && !dir_w[0] ##1 !pin_oe_o[0]);
   c_ana_out: cover property (ansel_w[0] && !dir_w[0] ##1 pin_oe_o[0] && ana_in_en_o[0]);
   c_decerr: cover property (avs_read_i && !avs_waitrequest_o && avs_response_o == `GP_RSP_DECERR);
endmodule : gp_top
`default_nettype wire

// file: gp_pad_model.sv
// Pad model: resolves each pin level from the port driver, an outside source and the pull-ups
`timescale 1ns/1ps
`default_nettype none
module gp_pad_model #(
   parameter int N = 40
) (
   // Clock
   input  wire logic         clk_i,
   // Port side of the pads
   input  wire logic [N-1:0] drv_i,
   input  wire logic [N-1:0] oe_i,
   input  wire logic [N-1:0] pu_i,
   // Outside source
   input  wire logic [N-1:0] ext_en_i,
   input  wire logic [N-1:0] ext_val_i,
   // Resolved pin levels
   output logic      [N-1:0] lvl_o
);
   logic [N-1:0] float_r;
   initial float_r = '0;
   // Undriven lines without pull-up wander every cycle
   always @(posedge clk_i) begin
      float_r <= ~float_r;
   end
   assign lvl_o = (oe_i & drv_i) | (~oe_i & ext_en_i & ext_val_i) | (~oe_i & ~ext_en_i & (pu_i | float_r));
endmodule : gp_pad_model
`default_nettype wire

// file: testbench.sv
// Self-checking testbench of the GPIO port block with its pad model
`timescale 1ns/1ps
`default_nettype none
`include "gp_params.svh"
module testbench;
   import gp_pkg::*;
   localparam int NPIN = 40;
   logic            clk_i, sys_rst_i, avs_read_i, avs_write_i, avs_waitrequest_o;
   logic [5:0]      avs_address_i;
   logic [31:0]     avs_writedata_i, avs_readdata_o, rd;
   logic [3:0]      avs_byteenable_i;
   logic [1:0]      avs_response_o, rsp;
   logic [31:0]     rdata_s, rd_s;
   logic [1:0]      resp_s, rsp_s;
   logic [NPIN-1:0] oe_s;
   logic [NPIN-1:0] pin_i, pin_o, pin_oe_o, pullup_en_o, slew_lim_o, ttl_sel_o, cfg_own_i, aout_en_i;
   logic [NPIN-1:0] ana_in_en_o, pps_en_i, pps_out_i, dig_in_o, ext_en, ext_val;
   logic [7:0]      sh [0:4][0:7];
   logic [7:0]      lv, d, a, od, c, ao, pe, po;
   int              err_count, num_checks, cyc, seed, p, r;

   gp_top #(.HAS_BANK_D(1'b1), .NPORT(5)) gp_top_i (.clk_i, .sys_rst_i, .avs_address_i, .avs_read_i,
      .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
      .avs_response_o, .pin_i, .pin_o, .pin_oe_o, .pullup_en_o, .slew_lim_o, .ttl_sel_o, .cfg_own_i,
      .aout_en_i, .ana_in_en_o, .pps_en_i, .pps_out_i, .dig_in_o);
   // Small variant without bank D on the same bus and pads
   if (1) begin : g_small
      gp_top #(.HAS_BANK_D(1'b0), .NPORT(5)) gp_top_i (.clk_i, .sys_rst_i, .avs_address_i, .avs_read_i,
         .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o(rdata_s), .avs_waitrequest_o(),
         .avs_response_o(resp_s), .pin_i, .pin_o(), .pin_oe_o(oe_s), .pullup_en_o(), .slew_lim_o(),
         .ttl_sel_o(), .cfg_own_i, .aout_en_i, .ana_in_en_o(), .pps_en_i, .pps_out_i, .dig_in_o());
   end
   gp_pad_model #(.N(NPIN)) gp_pad_model_i (.clk_i, .drv_i(pin_o), .oe_i(pin_oe_o), .pu_i(pullup_en_o),
      .ext_en_i(ext_en), .ext_val_i(ext_val), .lvl_o(pin_i));

   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      num_checks++;
      if (got !== ex) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, ex, got);
      end
   endtask : chk

   task automatic give_verdict;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : give_verdict

   // One Avalon transfer, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [5:0] ad, input logic [7:0] wd, input logic [3:0] be);
      @(posedge clk_i);
      avs_address_i    <= ad;
      avs_write_i      <= wr;
      avs_read_i       <= ~wr;
      avs_writedata_i  <= {24'h0, wd};
      avs_byteenable_i <= be;
      do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
      rd = avs_readdata_o;
      rsp = avs_response_o;
      rd_s = rdata_s;
      rsp_s = resp_s;
      avs_write_i <= 1'b0;
      avs_read_i  <= 1'b0;
   endtask : bus

   task automatic wr(input int pt, input int ri, input logic [7:0] wd);
      bus(1'b1, {pt[2:0], ri[2:0]}, wd, 4'h1);
      sh[pt][(ri == `GP_REG_LEVEL) ? `GP_REG_LATCH : ri] = wd;
   endtask : wr

   task automatic rdchk(input string nm, input int pt, input int ri, input logic [7:0] ex);
      bus(1'b0, {pt[2:0], ri[2:0]}, 8'h00, 4'h1);
      chk(nm, {`GP_RSP_OK, 22'h0, ex}, {rsp, rd[29:0]});
   endtask : rdchk

   function automatic logic [7:0] rst_val(input int ri);
      return (ri == `GP_REG_DIR || ri == `GP_REG_ANSEL) ? 8'hFF : 8'h00;
   endfunction : rst_val

   // Expected analog enable, output enable and driven data of one port
   function automatic logic [23:0] pad_exp(input logic [7:0] di, an, odr, la, cf, ao_, pe_, po_);
      logic [7:0] dat;
      logic [7:0] oe;
      dat = (pe_ & po_) | (~pe_ & la);
      oe = ~di & ~cf & ~ao_ & ~(odr & dat);
      return {an & ~cf & ~ao_, oe, dat & ~odr & oe};
   endfunction : pad_exp

   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc > 6000) begin
         err_count++;
         give_verdict();
      end
   end

   initial begin
      seed = 5372;
      {err_count, num_checks, cyc} = '0;
      sys_rst_i = 1'b1;
      {avs_read_i, avs_write_i, avs_address_i, avs_writedata_i, avs_byteenable_i} = '0;
      {cfg_own_i, aout_en_i, pps_en_i, pps_out_i, ext_en, ext_val} = '0;
      for (p = 0; p < 5; p++) for (r = 0; r < 8; r++) sh[p][r] = rst_val(r);
      repeat (8) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      for (p = 0; p < 5; p++) for (r = 0; r < 8; r++) rdchk("reset value", p, r, rst_val(r));
      chk("reset pads", 32'h0000_FF00, {16'h0, ana_in_en_o[7:0], pin_oe_o[7:0]});
      bus(1'b0, 6'h28, 8'h00, 4'h1);
      chk("unmapped read", {`GP_RSP_DECERR, 30'h0}, {rsp, rd[29:0]});
      rdchk("port D in large variant", `GP_PORT_D, `GP_REG_DIR, 8'hFF);
      chk("port D in small variant", {`GP_RSP_DECERR, 30'h0}, {rsp_s, rd_s[29:0]});
      wr(`GP_PORT_D, `GP_REG_DIR, 8'h00);
      repeat (2) @(posedge clk_i);
      chk("port D drive", 32'h0000_FF00, {16'h0, pin_oe_o[31:24], oe_s[31:24]});
      lv = $random(seed);
      wr(0, `GP_REG_ANSEL, 8'h00);
      wr(0, `GP_REG_DIR, 8'h00);
      wr(0, `GP_REG_LEVEL, lv);
      rdchk("latch after level write", 0, `GP_REG_LATCH, lv);
      repeat (6) @(posedge clk_i);
      chk("driven pads", {8'h0, lv, 8'hFF, lv}, {8'h0, pin_o[7:0], pin_oe_o[7:0], dig_in_o[7:0]});
      rdchk("level of driven pins", 0, `GP_REG_LEVEL, lv);
      ext_en[7:0] <= 8'hFF;
      ext_val[7:0] <= ~lv;
      wr(0, `GP_REG_DIR, 8'hFF);
      repeat (6) @(posedge clk_i);
      rdchk("level of input pins", 0, `GP_REG_LEVEL, ~lv);
      rdchk("latch kept", 0, `GP_REG_LATCH, lv);
      chk("released pads", 32'h0, {24'h0, pin_oe_o[7:0]});
      ext_en <= '0;
      wr(0, `GP_REG_DIR, 8'h00);
      wr(0, `GP_REG_ANSEL, 8'hFF);
      repeat (6) @(posedge clk_i);
      chk("analog pads", 32'h00FF_FF00, {8'h0, pin_oe_o[7:0], ana_in_en_o[7:0], dig_in_o[7:0]});
      rdchk("analog level", 0, `GP_REG_LEVEL, 8'h00);
      for (int i = 0; i < 24; i++) begin
         {d, a, od, lv} = {$random(seed)};
         {c, ao, pe, po} = {$random(seed)};
         if (i == 0) c = 8'hFF;
         if (i == 1) ao = 8'hFF;
         if (i == 2) pe = 8'hFF;
         wr(0, `GP_REG_DIR, d);
         wr(0, `GP_REG_ANSEL, a);
         wr(0, `GP_REG_ODRAIN, od);
         wr(0, `GP_REG_LATCH, lv);
         cfg_own_i <= {$random(seed), c};
         aout_en_i <= {$random(seed), ao};
         pps_en_i <= {$random(seed), pe};
         pps_out_i <= {$random(seed), po};
         repeat (3) @(posedge clk_i);
         chk("pad ownership", {8'h0, pad_exp(d, a, od, lv, c, ao, pe, po)},
             {8'h0, ana_in_en_o[7:0], pin_oe_o[7:0], pin_o[7:0] & pin_oe_o[7:0]});
      end
      {cfg_own_i, aout_en_i, pps_en_i, pps_out_i} <= '0;
      for (int i = 0; i < 60; i++) begin
         p = {$random(seed)} % 5;
         r = 1 + {$random(seed)} % 7;
         d = $random(seed);
         if (i % 10 == 0) bus(1'b1, {p[2:0], r[2:0]}, d, 4'h0);
         else begin
            wr(p, r, d);
            sh[p][r] = d;
         end
         rdchk("register readback", p, r, sh[p][r]);
         chk("pad control", {8'h0, sh[p][4], sh[p][6], sh[p][5]},
             {8'h0, pullup_en_o[p*8+:8], slew_lim_o[p*8+:8], ttl_sel_o[p*8+:8]});
      end
      sys_rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      rdchk("direction after second reset", 2, `GP_REG_DIR, 8'hFF);
      rdchk("analog after second reset", 4, `GP_REG_ANSEL, 8'hFF);
      give_verdict();
   end
endmodule : testbench
`default_nettype wire
